/* File: src/mcs_sequencer.sv */
// multichannel sequencer: capture bookkeeping, main frame rotation, aux control
// assumes decoder/capture events are one-cycle pulses synchronous to mclk
//
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
// Behaviour
// R1: with multichannel enabled, up to four channels are rotated frame by frame.
// R2: multichannel mode withdraws picture-in-picture and dual output.
// R3: sources beyond two channels time-multiplex using embedded-sync formats.
// R4: four channels all on one port, or two per port, at most four.
// R5: decoders A1,A2 feed channels one, two; B1,B2 feed three, four.
// R6: port A decoders capture on capture clock A, port B on B; code gives decoders 2,3 clock B and 0,1 clock A regardless of port.
// R7: channel ids come from reference-code protection bits or blanking; readable.
// R8: each captured field triggers exactly one main sync frame.
// R9: captured frames are processed in main timing and passed to aux.
// R10: software keeps main frame period within input period over channel count.
// R11: offset and scale per channel; other main settings shared.
// R12: input colour conversion, front filter and front converter disabled.
// R13: horizontal halving applies to every channel together.
// R14: overlay-to-aux bit: zero disables, one enables main overlay on aux.
// R15: per-channel sprite bit routes sprite pairs to channels, else all.
// R16: aux scaler applies one shared offset, size and downscale.
// R17: aux path reads back all stored channels at once.
// R18: multichannel output is frame-synchronous, time-multiplexed on one clock.
// R19: four ports with muxed Y/C, two with separate Y/C.
// R20: output channel id goes into protection bits or blanking.
// R21: multichannel output bypasses further video processing.
// R22: multiwindow upscales into 2x2,1x4,4x1,1x2,2x1 with csc and overlay.
// R23: each captured channel served once per cycle, fixed order.
module mcs_sequencer
  import mcs_pkg::*;
#(
  parameter int PERIOD_W = 24
)(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [3:0] dec_sav_strobe,
  input wire logic [3:0] dec_id_prot,
  input wire logic [3:0] dec_id_hblank,
  input wire logic [3:0] capture_done,
  output logic [3:0] decoder_enable,
  output logic [3:0] decoder_on_port_b,
  output logic [3:0] capture_on_port_b_clock,
  output logic dual_scaler_allowed,
  output logic front_block_enable,
  output logic half_width_all,
  output logic main_frame_start,
  output logic main_vact,
  output logic [1:0] main_channel,
  output logic [15:0] main_ch_offset,
  output logic [15:0] main_ch_scale,
  output logic [7:0] sprite_enable,
  output logic overlay_to_aux_path_enable,
  output logic aux_in_valid,
  output logic [1:0] aux_in_channel,
  output logic [31:0] aux_offset,
  output logic [31:0] aux_size,
  output logic [3:0] aux_read_mask,
  output logic out_multiwindow,
  output logic out_sep_yc,
  output logic [3:0] out_port_enable,
  output logic out_id_insert,
  output logic out_id_in_hblank,
  output logic out_bypass,
  output logic [2:0] win_layout,
  output logic win_csc_en,
  output logic win_osd_en
);
  logic rst_s1;
  logic rst_q;
  logic [31:0] ctrl;
  logic [31:0] outcfg;
  logic [PERIOD_W-1:0] period;
  logic [31:0] aux_ofs_r;
  logic [31:0] aux_size_r;
  logic [31:0] chcfg [NCH];
  logic [15:0] chid;
  logic [3:0] pending;
  logic [1:0] rot_ptr;
  logic [PERIOD_W-1:0] frame_cnt;
  mcs_state_t state;
  logic wr_en;
  logic rd_ack;
  logic [3:0] ch_active;
  logic [2:0] nch;
  logic [1:0] next_pick;
  logic next_found;
  logic [3:0] serve_clr;
  logic start_frame;
  logic [2:0] nport;
  logic [2:0] nport_lim;

  // two-stage reset release, only constants under the asynchronous term
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1 <= 1'b0;
      rst_q <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_q <= rst_s1;
    end
  end

  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign rd_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // channel count clamps at four; arrangement fixes which decoders run
  assign nch = (ctrl[C_NCH_LSB +: 3] > 3'h4 || ctrl[C_NCH_LSB +: 3] == 3'h0) ?
               3'h4 : ctrl[C_NCH_LSB +: 3];
  always_comb
  begin
    ch_active = 4'h0;
    for (int i = 0; i < NCH; i++)
    begin
      if (ctrl[C_SPLIT])
        ch_active[i] = (i % 2) < (nch + 3'h1) / 3'h2; // R4
      else
        ch_active[i] = i < nch; // R4
    end
  end

  // pick the next pending channel in the fixed rotation after the last one
  always_comb
  begin
    logic [1:0] pos;
    logic [1:0] ch;
    pos = 2'h0;
    ch = 2'h0;
    next_pick = 2'h0;
    next_found = 1'b0;
    for (int k = 0; k < NCH; k++)
    begin
      pos = rot_ptr + k[1:0];
      ch = ROT_ORDER[pos*2 +: 2];
      if (!next_found && pending[ch])
      begin
        next_found = 1'b1; // R23
        next_pick = ch;
      end
    end
  end

  assign start_frame = (state == MCS_IDLE) && ctrl[C_MCH_EN] && next_found; // R1
  assign serve_clr = start_frame ? (4'h1 << next_pick) : 4'h0;

  // wishbone: one-cycle registered ack, unmapped reads give zero, writes drop
  always_ff @(posedge mclk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= rd_ack;
      if (rd_ack && !wb_we_i)
      begin
        case (wb_adr_i)
          A_CTRL: wb_dat_o <= ctrl;
          A_OUTCFG: wb_dat_o <= outcfg;
          A_PERIOD: wb_dat_o <= 32'(period);
          A_AUXOFS: wb_dat_o <= aux_ofs_r;
          A_AUXSIZE: wb_dat_o <= aux_size_r;
          A_STATUS: wb_dat_o <= {22'h0, state == MCS_FRAME, main_channel, rot_ptr,
                                 pending, ch_active[0]};
          A_CHID: wb_dat_o <= {16'h0, chid}; // R7
          A_CHCFG0: wb_dat_o <= chcfg[0];
          A_CHCFG0 + 8'h04: wb_dat_o <= chcfg[1];
          A_CHCFG0 + 8'h08: wb_dat_o <= chcfg[2];
          A_CHCFG0 + 8'h0C: wb_dat_o <= chcfg[3];
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // byte-lane writes into the writable registers
  always_ff @(posedge mclk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      ctrl <= CTRL_RST;
      outcfg <= OUTCFG_RST;
      period <= PERIOD_W'(PERIOD_RST);
      aux_ofs_r <= 32'h0000_0000;
      aux_size_r <= 32'h0000_0000;
      for (int i = 0; i < NCH; i++)
        chcfg[i] <= 32'h0001_0000;
    end
    else if (wr_en)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (wb_sel_i[b])
        begin
          case (wb_adr_i)
            A_CTRL: ctrl[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            A_OUTCFG: outcfg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            A_AUXOFS: aux_ofs_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8]; // R16
            A_AUXSIZE: aux_size_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8]; // R16
            A_CHCFG0: chcfg[0][b*8 +: 8] <= wb_dat_i[b*8 +: 8]; // R11
            A_CHCFG0 + 8'h04: chcfg[1][b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            A_CHCFG0 + 8'h08: chcfg[2][b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            A_CHCFG0 + 8'h0C: chcfg[3][b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            A_PERIOD:
            begin
              if (b < 3)
                period[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
            default: ;
          endcase
        end
      end
    end
  end

  // channel id capture, from protection bits or blanking data per select
  always_ff @(posedge mclk or negedge rst_q)
  begin
    if (!rst_q)
      chid <= 16'h0000;
    else
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (dec_sav_strobe[i] && ch_active[i])
          chid[i*4 +: 4] <= ctrl[C_ID_HBLANK] ? dec_id_hblank : dec_id_prot; // R7
      end
    end
  end

  // pending captures: a new capture wins over the clear from a serve
  always_ff @(posedge mclk or negedge rst_q)
  begin
    if (!rst_q)
      pending <= 4'h0;
    else if (!ctrl[C_MCH_EN])
      pending <= 4'h0;
    else
      pending <= (pending & ~serve_clr) | (capture_done & ch_active); // R8
  end

  // main sync generator: one frame of period cycles per captured field
  always_ff @(posedge mclk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      state <= MCS_IDLE;
      frame_cnt <= '0;
      rot_ptr <= 2'h0;
      main_frame_start <= 1'b0;
      main_vact <= 1'b0;
      main_channel <= 2'h0;
      main_ch_offset <= 16'h0000;
      main_ch_scale <= 16'h0000;
      sprite_enable <= 8'h00;
    end
    else
    begin
      main_frame_start <= start_frame; // R8
      case (state)
        MCS_IDLE:
        begin
          if (start_frame)
          begin
            state <= MCS_FRAME;
            frame_cnt <= (period == '0) ? PERIOD_W'(1) : period;
            main_vact <= 1'b1; // R9
            main_channel <= next_pick;
            main_ch_offset <= chcfg[next_pick][15:0]; // R11
            main_ch_scale <= chcfg[next_pick][31:16]; // R11
            for (int k = 0; k < NCH; k++)
            begin
              if (ROT_ORDER[k*2 +: 2] == next_pick)
                rot_ptr <= 2'(k + 1); // R23
            end
            if (ctrl[C_SPR_MCH])
              sprite_enable <= {4'h1, 4'h1} << next_pick; // R15
            else
              sprite_enable <= 8'hFF; // R15
          end
        end
        MCS_FRAME:
        begin
          frame_cnt <= frame_cnt - PERIOD_W'(1);
          if (frame_cnt == PERIOD_W'(1))
          begin
            state <= MCS_IDLE; // R8
            main_vact <= 1'b0;
          end
        end
        default:
        begin
          state <= MCS_IDLE;
          main_vact <= 1'b0;
        end
      endcase
    end
  end

  // output port count limited by the Y/C format
  assign nport_lim = outcfg[O_SEPYC] ? MAX_PORTS_SEP : MAX_PORTS_MUX;
  assign nport = (outcfg[O_NPORT_LSB +: 3] > nport_lim) ? nport_lim :
                 outcfg[O_NPORT_LSB +: 3];

  // static mode outputs, registered so every output comes from a flop
  always_ff @(posedge mclk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      decoder_enable <= 4'h0;
      decoder_on_port_b <= 4'h0;
      capture_on_port_b_clock <= 4'h0;
      dual_scaler_allowed <= 1'b0;
      front_block_enable <= 1'b0;
      half_width_all <= 1'b0;
      overlay_to_aux_path_enable <= 1'b0;
      aux_in_valid <= 1'b0;
      aux_in_channel <= 2'h0;
      aux_offset <= 32'h0000_0000;
      aux_size <= 32'h0000_0000;
      aux_read_mask <= 4'h0;
      out_multiwindow <= 1'b0;
      out_sep_yc <= 1'b0;
      out_port_enable <= 4'h0;
      out_id_insert <= 1'b0;
      out_id_in_hblank <= 1'b0;
      out_bypass <= 1'b0;
      win_layout <= L_2X2;
      win_csc_en <= 1'b0;
      win_osd_en <= 1'b0;
    end
    else
    begin
      decoder_enable <= ctrl[C_MCH_EN] ? ch_active : 4'h0; // R5
      for (int i = 0; i < NCH; i++)
      begin
        // split mode: A1,A2 on port A, B1,B2 on port B; else one shared port
        decoder_on_port_b[i] <= ctrl[C_SPLIT] ? (i >= 2) : ctrl[C_ONE_PORT_B]; // R5
        capture_on_port_b_clock[i] <= (i >= 2); // R6
      end
      dual_scaler_allowed <= !ctrl[C_MCH_EN]; // R2
      front_block_enable <= !ctrl[C_MCH_EN]; // R12
      half_width_all <= ctrl[C_MCH_EN] && ctrl[C_HDECIM]; // R13
      overlay_to_aux_path_enable <= ctrl[C_OSD_AUX]; // R14
      // drop on the last counted cycle so the valid window matches main_vact exactly
      aux_in_valid <= start_frame || (state == MCS_FRAME && frame_cnt != PERIOD_W'(1)); // R9
      aux_in_channel <= start_frame ? next_pick : main_channel; // R9
      aux_offset <= aux_ofs_r; // R16
      aux_size <= aux_size_r; // R16
      aux_read_mask <= ctrl[C_MCH_EN] ? ch_active : 4'h0; // R17
      out_multiwindow <= outcfg[O_MWIN];
      out_sep_yc <= outcfg[O_SEPYC]; // R18
      for (int p = 0; p < 4; p++)
        out_port_enable[p] <= !outcfg[O_MWIN] && ctrl[C_MCH_EN] && (p < nport); // R19
      out_id_insert <= !outcfg[O_MWIN] && outcfg[O_ID_INS]; // R20
      out_id_in_hblank <= outcfg[O_ID_HBLANK]; // R20
      out_bypass <= !outcfg[O_MWIN]; // R21
      // unknown layout codes fall back to the 2x2 grid
      win_layout <= (outcfg[O_LAYOUT_LSB +: 3] > L_2X1) ? L_2X2 :
                    outcfg[O_LAYOUT_LSB +: 3]; // R22
      win_csc_en <= outcfg[O_MWIN] && outcfg[O_CSC]; // R22
      win_osd_en <= outcfg[O_MWIN] && outcfg[O_OSD]; // R22
    end
  end
endmodule : mcs_sequencer

/* File: src/mcs_pkg.sv */
// package for the multichannel video sequencer: map, fields, states, resets
// assumes a 32-bit classic wishbone slave decoding byte addresses
package mcs_pkg;
  localparam int NCH = 4;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_OUTCFG = 8'h04;
  localparam logic [7:0] A_PERIOD = 8'h08;
  localparam logic [7:0] A_AUXOFS = 8'h0C;
  localparam logic [7:0] A_AUXSIZE = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_CHID = 8'h18;
  localparam logic [7:0] A_CHCFG0 = 8'h20;
  // control fields
  localparam int C_MCH_EN = 0;
  localparam int C_SPLIT = 1;
  localparam int C_ONE_PORT_B = 2;
  localparam int C_HDECIM = 3;
  localparam int C_OSD_AUX = 4;
  localparam int C_SPR_MCH = 5;
  localparam int C_ID_HBLANK = 6;
  localparam int C_NCH_LSB = 8;
  // output configuration fields
  localparam int O_MWIN = 0;
  localparam int O_SEPYC = 1;
  localparam int O_ID_INS = 2;
  localparam int O_ID_HBLANK = 3;
  localparam int O_CSC = 4;
  localparam int O_OSD = 5;
  localparam int O_NPORT_LSB = 8;
  localparam int O_LAYOUT_LSB = 12;
  localparam logic [31:0] CTRL_RST = 32'h0000_0300;
  localparam logic [31:0] OUTCFG_RST = 32'h0000_0000;
  localparam logic [23:0] PERIOD_RST = 24'h00_0100;
  localparam logic [2:0] MAX_PORTS_MUX = 3'h4;
  localparam logic [2:0] MAX_PORTS_SEP = 3'h2;
  // window layouts
  localparam logic [2:0] L_2X2 = 3'h0;
  localparam logic [2:0] L_1X4 = 3'h1;
  localparam logic [2:0] L_4X1 = 3'h2;
  localparam logic [2:0] L_1X2 = 3'h3;
  localparam logic [2:0] L_2X1 = 3'h4;
  // service order ch0, ch2, ch1, ch3 (zero based)
  localparam logic [7:0] ROT_ORDER = 8'hD8;
  typedef enum logic [1:0] {
    MCS_IDLE = 2'b01,
    MCS_FRAME = 2'b10
  } mcs_state_t;
endpackage : mcs_pkg

/* File: tb/mcs_sequencer_asserts.sv */
// port checker for the sequencer: bus answer, frame timing, routing
// assumes one clock, mclk, and rst_n as the asynchronous low reset
`timescale 1ns/100ps
module mcs_chk
  import mcs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [3:0] decoder_enable,
  input wire logic [3:0] capture_on_port_b_clock,
  input wire logic dual_scaler_allowed,
  input wire logic front_block_enable,
  input wire logic half_width_all,
  input wire logic main_frame_start,
  input wire logic main_vact,
  input wire logic [1:0] main_channel,
  input wire logic [7:0] sprite_enable,
  input wire logic aux_in_valid,
  input wire logic [1:0] aux_in_channel,
  input wire logic out_multiwindow,
  input wire logic out_sep_yc,
  input wire logic [3:0] out_port_enable
);
  logic [1:0] up_cnt;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // outputs lag the release by the two synchroniser flops and their own output flop, so wait them out
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      up_cnt <= 2'h0;
    else if (up_cnt != 2'h3)
      up_cnt <= up_cnt + 2'h1;
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_bus_answer: assert property (s_req |=> s_ack_once)
    else $error("bus ack missing or too long");
  chk_mch_withdraw: assert property (up_cnt == 2'h3 |->
    dual_scaler_allowed == (decoder_enable == 4'h0) && front_block_enable == dual_scaler_allowed)
    else $error("shared path flags disagree with mode");
  chk_half_scope: assert property (half_width_all |-> decoder_enable != 4'h0)
    else $error("half width outside multichannel mode");
  chk_capture_clock: assert property (up_cnt == 2'h3 |-> capture_on_port_b_clock == 4'hC)
    else $error("capture clock map wrong");
  chk_frame_start: assert property (main_frame_start |-> main_vact && !$past(main_vact))
    else $error("frame start not at a fresh frame");
  chk_vact_start: assert property ($rose(main_vact) |-> main_frame_start)
    else $error("frame began without start pulse");
  chk_aux_follow: assert property ((main_vact || aux_in_valid) |->
    main_vact && aux_in_valid && aux_in_channel == main_channel)
    else $error("aux input not aligned with main frame");
  chk_channel_hold: assert property (main_vact && !main_frame_start |-> $stable(main_channel))
    else $error("channel changed inside a frame");
  chk_sprite_pair: assert property (up_cnt == 2'h3 && main_vact && sprite_enable != 8'hFF |->
    sprite_enable[7:4] == sprite_enable[3:0] && $onehot(sprite_enable[3:0]))
    else $error("sprite routing not a channel pair");
  chk_port_limit: assert property (out_multiwindow || out_sep_yc |->
    out_port_enable[3:2] == 2'h0 && (!out_multiwindow || out_port_enable == 4'h0))
    else $error("output ports exceed the format limit");
endmodule : mcs_chk
bind mcs_sequencer mcs_chk u_chk (.*);

/* File: tb/mcs_src_model.sv */
// far-side source model: sync-embedded streams seen as decoder events
// assumes the bench pulses go for one cycle and waits for the frame to pass
`timescale 1ns/100ps
module mcs_src_model
(
  input wire logic mclk,
  input wire logic go,
  input wire logic [3:0] mask,
  input wire logic [3:0] id,
  input wire logic [3:0] gap,
  output logic [3:0] dec_sav_strobe,
  output logic [3:0] dec_id_prot,
  output logic [3:0] dec_id_hblank,
  output logic [3:0] capture_done
);
  initial
  begin
    dec_sav_strobe = 4'h0;
    dec_id_prot = 4'h0;
    dec_id_hblank = 4'hF;
    capture_done = 4'h0;
  end
  // ids are valid only on the strobe; inverted after it so a late sample fails
  always @(posedge mclk)
  begin
    if (go)
    begin
      dec_sav_strobe <= mask;
      dec_id_prot <= id;
      dec_id_hblank <= ~id;
      @(posedge mclk);
      dec_sav_strobe <= 4'h0;
      dec_id_prot <= ~id;
      dec_id_hblank <= id;
      repeat (gap) @(posedge mclk);
      capture_done <= mask;
      @(posedge mclk);
      capture_done <= 4'h0;
    end
  end
endmodule : mcs_src_model

/* File: tb/tb_top.sv */
// self-checking bench for the sequencer: registers, rotation, reset
// assumes the source model drives the decoder events
`timescale 1ns/100ps
module tb_top
  import mcs_pkg::*;
();
  typedef struct packed {logic [7:0] adr; logic [31:0] wd; logic [31:0] exp;} mcs_row_t;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0, src_mask = 4'h0, src_id = 4'h0, src_gap = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, aux_offset, aux_size, rdv;
  logic wb_ack_o, src_go = 1'b0, dual_scaler_allowed, front_block_enable, half_width_all;
  logic main_frame_start, main_vact, overlay_to_aux_path_enable, aux_in_valid;
  logic out_multiwindow, out_sep_yc, out_id_insert, out_id_in_hblank, out_bypass;
  logic win_csc_en, win_osd_en;
  logic [3:0] dec_sav_strobe, dec_id_prot, dec_id_hblank, capture_done, decoder_enable;
  logic [3:0] decoder_on_port_b, capture_on_port_b_clock, out_port_enable, aux_read_mask;
  logic [1:0] main_channel, aux_in_channel;
  logic [15:0] main_ch_offset, main_ch_scale;
  logic [7:0] sprite_enable;
  logic [2:0] win_layout;
  int num_errors = 0;
  int checks_done = 0;
  mcs_row_t rows [6] = '{'{A_AUXOFS, 32'hA5A5_1234, 32'hA5A5_1234},
    '{A_AUXSIZE, 32'h0438_0780, 32'h0438_0780}, '{A_PERIOD, 32'hFF00_0004, 32'h0000_0004},
    '{A_CHCFG0 + 8'h04, 32'h0030_0020, 32'h0030_0020}, '{8'h40, 32'hFFFF_FFFF, 32'h0},
    '{A_OUTCFG, 32'h0000_4233, 32'h0000_4233}};
  always #4 mclk = ~mclk;
  mcs_sequencer u_dut (.*);
  mcs_src_model u_src (.go(src_go), .mask(src_mask), .id(src_id), .gap(src_gap), .*);
  task automatic wrap_up();
    if (num_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : tick
  // one classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n = 0;
    @(posedge mclk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, we, adr, dat, 4'hF};
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    rdv = wb_dat_o;
    chk(32'(n), 32'h2);
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask : wb
  task automatic send(input logic [3:0] m, input logic [3:0] id, input logic [3:0] g);
    @(posedge mclk);
    {src_go, src_mask, src_id, src_gap} <= {1'b1, m, id, g};
    @(posedge mclk);
    src_go <= 1'b0;
  endtask : send
  task automatic frame(input logic [1:0] ch);
    int n = 0;
    while (main_frame_start !== 1'b1 && n < 100)
    begin
      tick(1);
      n++;
    end
    chk(32'(main_channel), 32'(ch));
    chk(32'(sprite_enable), 32'(8'h11 << ch));
    chk(32'(main_ch_offset), (ch == 2'h1) ? 32'h20 : 32'h0);
    chk(32'(main_ch_scale), (ch == 2'h1) ? 32'h30 : 32'h1);
    chk({aux_in_valid, aux_in_channel}, {1'b1, ch});
    for (n = 0; main_vact === 1'b1 && n < 100; n++)
      tick(1);
    chk(32'(n), 32'h4);
  endtask : frame
  task automatic quiet();
    int n = 0;
    repeat (30)
    begin
      tick(1);
      n += int'(main_vact === 1'b1);
    end
    chk(32'(n), 32'h0);
  endtask : quiet
  // a hang is cut short well after the sequence should have ended
  initial
  begin
    #100000;
    num_errors++;
    wrap_up();
  end
  initial
  begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    tick(2);
    wb(1'b0, A_CTRL, 32'h0);
    chk(rdv, CTRL_RST);
    wb(1'b0, A_CHCFG0, 32'h0);
    chk(rdv, 32'h0001_0000);
    chk(32'(dual_scaler_allowed), 32'h1);
    foreach (rows[i])
    begin
      wb(1'b1, rows[i].adr, rows[i].wd);
      wb(1'b0, rows[i].adr, 32'h0);
      chk(rdv, rows[i].exp);
    end
    chk(aux_offset, 32'hA5A5_1234);
    chk(aux_size, 32'h0438_0780);
    chk({win_csc_en, win_osd_en, out_bypass}, 32'h6);
    chk(32'(win_layout), 32'h4);
    wb(1'b1, A_CTRL, 32'h0000_0419);
    tick(2);
    chk({half_width_all, overlay_to_aux_path_enable, front_block_enable}, 32'h6);
    chk({aux_read_mask, decoder_enable, decoder_on_port_b, capture_on_port_b_clock},
      32'hFF0C);
    wb(1'b1, A_CTRL, 32'h0000_0405);
    tick(2);
    chk({overlay_to_aux_path_enable, decoder_on_port_b}, 32'hF);
    wb(1'b1, A_CTRL, 32'h0000_0403);
    tick(2);
    chk(32'(decoder_on_port_b), 32'hC);
    wb(1'b1, A_CTRL, 32'h0000_0203);
    wb(1'b1, A_OUTCFG, 32'h0000_003C);
    tick(2);
    chk(32'(decoder_enable), 32'h5);
    chk({out_multiwindow, out_sep_yc, out_bypass, out_id_insert, out_id_in_hblank}, 32'h7);
    chk({win_csc_en, win_osd_en}, 32'h0);
    for (int v = 0; v < 3; v++)
    begin
      // separate Y/C asking for three, muxed asking for three, muxed asking for seven
      wb(1'b1, A_OUTCFG, (v == 0) ? 32'h0000_0302 : (v == 1) ? 32'h0000_0300 : 32'h0000_0700);
      tick(2);
      chk(32'(out_port_enable), (v == 0) ? 32'h3 : (v == 1) ? 32'h7 : 32'hF);
    end
    for (int v = 0; v < 6; v++)
    begin
      wb(1'b1, A_OUTCFG, 32'h0000_0301 | (32'(v) << 12));
      tick(2);
      chk({out_port_enable, 1'b0, win_layout}, (v > 4) ? 32'h0 : 32'(v));
    end
    wb(1'b1, A_CTRL, 32'h0000_0421);
    send(4'hF, 4'h9, 4'h0);
    frame(2'h0);
    frame(2'h2);
    frame(2'h1);
    frame(2'h3);
    quiet();
    wb(1'b0, A_CHID, 32'h0);
    chk(rdv, 32'h0000_9999);
    wb(1'b1, A_CTRL, 32'h0000_0461);
    send(4'h5, 4'hA, 4'h5);
    frame(2'h0);
    frame(2'h2);
    wb(1'b0, A_CHID, 32'h0);
    chk(rdv, 32'h0000_9595);
    wb(1'b1, A_CTRL, 32'h0000_0400);
    send(4'hF, 4'h3, 4'h0);
    quiet();
    chk({aux_read_mask, decoder_enable, 3'h0, dual_scaler_allowed}, 32'h1);
    wb(1'b1, A_CTRL, 32'h0000_0419);
    @(posedge mclk);
    rst_n <= 1'b0;
    tick(3);
    chk({decoder_enable, 3'h0, half_width_all}, 32'h0);
    @(posedge mclk);
    rst_n <= 1'b1;
    tick(2);
    wb(1'b0, A_CTRL, 32'h0);
    chk(rdv, CTRL_RST);
    wrap_up();
  end
endmodule : tb_top
